// *** hw/dbas_pkg.sv ***
// Constants shared by the disk bus adapter status block: register map,
// status bit positions, reset values and timing counts.
// Assumes a 125 MHz backplane clock driving every counter.
package dbas_pkg;
	localparam logic [11:0] CTRL_OFS = 12'h004;
	localparam logic [11:0] STAT_OFS = 12'h008;
	localparam logic [11:0] VADDR_OFS = 12'h00C;
	localparam logic [11:0] BCNT_OFS = 12'h010;
	localparam logic [1:0] MAP_SEL = 2'h2;
	localparam int CTRL_INIT = 0;
	localparam int CTRL_ABORT = 1;
	localparam int CTRL_IE = 2;
	localparam int CTRL_MAINT = 3;
	localparam logic IE_RESET = 1'b1;
	localparam int ST_BUSY = 31;
	localparam int ST_NO_RESPONSE_FLAG = 30;
	localparam int ST_CRD = 29;
	localparam int ST_PGE = 19;
	localparam int ST_NFD = 18;
	localparam int ST_CONTROL_PARITY_FLAG = 17;
	localparam int ST_ATTENTION_FLAG = 16;
	localparam int ST_CMP = 13;
	localparam int ST_ABT = 12;
	localparam int ST_DLT = 11;
	localparam int ST_WCKU = 10;
	localparam int ST_WCKL = 9;
	localparam int ST_MXF = 8;
	localparam int ST_EXC = 7;
	localparam int ST_DPE = 6;
	localparam int ST_MAP_PARITY_FLAG = 5;
	localparam int ST_INVALID_MAP_FLAG = 4;
	localparam int ST_ERRCF = 3;
	localparam int ST_RDS = 2;
	localparam int ST_ISTO = 1;
	localparam int ST_RDTO = 0;
	// Flags that stop a running transfer when they get set.
	localparam logic [31:0] ABORT_MASK = 32'h00000EFF & ~32'h00000100;
	// Flags that raise the processor interrupt when enabled.
	localparam logic [31:0] IRQ_MASK = 32'h000F3100;
	localparam logic [31:0] STAT_W1C = 32'h600E3FFF;
	localparam int MAP_VALID = 22;
	localparam int MAP_PAR = 21;
	localparam logic [31:0] VADDR_STEP = 32'h00000008;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int NFD_TIME_NS = 1500;
	localparam logic [7:0] NFD_CYC = 8'((NFD_TIME_NS * 1000) / CLK_PERIOD_PS);
	localparam int MXF_TIME_US = 500;
	localparam int MXF_CYC_DEF = (MXF_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int SEQ_TIME_PS = 102400000;
	localparam int SEQ_CYC_DEF = SEQ_TIME_PS / CLK_PERIOD_PS;
	localparam logic [3:0] INIT_HOLD_CYC = 4'hF;
	localparam logic [1:0] MODE_READ = 2'h0;
	localparam logic [1:0] MODE_WRITE = 2'h1;
	localparam logic [1:0] MODE_WCHECK = 2'h2;
	typedef enum logic [1:0] {
		X_IDLE = 2'b00,
		X_RUN = 2'b01,
		X_ABWAIT = 2'b10,
		X_ABEBL = 2'b11
	} dbas_xfer_t;
endpackage : dbas_pkg

// *** hw/dbas_status.sv ***
// Status, initialize, watchdog and virtual address logic of the disk bus
// adapter, reached from software over APB.
// Assumes the data path and backplane logic on clk report events as
// one-cycle pulses; drive-bus lines arrive asynchronously and are synchronised.
//
// Behaviour
// - Initialize bit self-clears, always reads zero.
// - Initialize clears state, aborts, pulses drive init.
// - Busy set on command, cleared at end.
// - No-response sets flag and retries command.
// - Corrected read tag sets flag.
// - Illegal loads during transfer set program error.
// - No acknowledge within 1.5 us flags drive.
// - Control parity error sets flag, interrupts.
// - Attention line mirrored, requests interrupt.
// - Normal or aborted transfer end sets complete flag; initialize clears it.
// - Aborted flag set at end-block falling edge.
// - Buffer underrun or overrun sets data late.
// - Write-check byte mismatch sets flag, aborts.
// - No sync or occupied in 500 us.
// - Drive exception or data parity aborts.
// - Map parity mismatch sets flag, aborts.
// - Invalid next map entry aborts transfer.
// - Error confirm or substitute tag aborts.
// - Backplane sequence over 102.4 us aborts.
// - Read data return over 102.4 us aborts.
// - Address bits select map entry, offset.
// - Address advances eight per memory access.
// - Abort stops the 500 us counter, drops run, asserts execute.
// - Interrupt enable set at reset, cleared by initialize.
// - Map entry holds valid bit and frame number.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dbas_status
	import dbas_pkg::*;
#(
	parameter int MXF_CYC = MXF_CYC_DEF,
	parameter int SEQ_CYC = SEQ_CYC_DEF
)(
	input wire logic clk, // backplane clock
	input wire logic rst, // async reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped access
	output logic [31:0] prdata, // APB read data
	input wire logic xferCmd, // data transfer command seen
	input wire logic [1:0] xferMode, // read, write or write-check
	input wire logic xferDone, // normal end of transfer
	input wire logic byteCountNonzero, // bytes remain
	input wire logic memXfer, // one memory quadword moved
	input wire logic noRespConf, // backplane no-response confirm
	input wire logic errConf, // backplane error confirm
	input wire logic readCorrected, // read data tagged corrected
	input wire logic readSubstitute, // read data tagged substitute
	input wire logic seqStart, // arbitration begun
	input wire logic seqEnd, // sequence acknowledged or errored
	input wire logic readSeqDone, // read sequence completed
	input wire logic readDataBack, // read data returned
	input wire logic wclkSent, // write clock sent to drive
	input wire logic bufEmpty, // data buffer empty
	input wire logic bufFull, // data buffer full
	input wire logic ctlParityErr, // control path parity error
	input wire logic dataParityErr, // drive data parity error
	input wire logic wcStrobe, // write-check word ready
	input wire logic [15:0] wcMemWord, // word from memory
	input wire logic [15:0] wcDriveWord, // word from drive
	input wire logic demandReq, // control path wants the drive
	input wire logic transfer_acknowledge, // drive acknowledge pin
	input wire logic end_of_block, // drive end-of-block pin
	input wire logic drive_exception_line, // drive exception pin
	input wire logic occupied_line, // drive occupied pin
	input wire logic attention_line, // drive attention pin
	input wire logic syncClock, // drive sync clock pin
	output logic demand_line, // demand to drive
	output logic runLine, // run to drive
	output logic execute_line, // execute to drive
	output logic driveInit, // init to drive bus
	output logic adapterInit, // one-cycle clear for other blocks
	output logic retryCmd, // reissue last backplane command
	output logic missingDriveZero, // return zero read data
	output logic byteCountWrite, // byte counter load strobe
	output logic [29:0] physAddr, // mapped memory address
	output logic irq // processor interrupt
);
	typedef struct packed {
		dbas_xfer_t xs;
		logic abortBit;
		logic ie;
		logic maint;
		logic [31:0] stat;
		logic [31:0] vaddr;
		logic [255:0][22:0] map;
		logic [29:0] physAddr;
		logic [5:0] sy1;
		logic [5:0] sy2;
		logic [5:0] sy3;
		logic [7:0] nfdCnt;
		logic nfdDone;
		logic [16:0] mxfCnt;
		logic mxfOn;
		logic [14:0] seqCnt;
		logic seqOn;
		logic [14:0] rdCnt;
		logic rdOn;
		logic [3:0] initCnt;
		logic initPulse;
		logic retry;
		logic zeroData;
	} dbas_state_t;

	dbas_state_t cur;
	dbas_state_t next_cur;
	logic wr;
	logic rd;
	logic isMap;
	logic mapped;
	logic busy;
	logic [31:0] setv;
	logic [31:0] w1c;
	logic [31:0] newVaddr;
	logic [22:0] entry;
	logic [31:0] statRead;
	logic sclkEdge;
	logic eblHigh;
	logic eblFell;
	logic excRose;
	logic abortEv;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign isMap = paddr[11:10] == MAP_SEL;
	assign mapped = isMap || paddr == CTRL_OFS || paddr == STAT_OFS || paddr == VADDR_OFS
		|| paddr == BCNT_OFS;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (!mapped || paddr[1:0] != 2'h0);
	assign busy = cur.xs != X_IDLE;
	// Synchroniser bits: 0 ack, 1 end-block, 2 exception, 3 occupied, 4 attention, 5 sync.
	assign sclkEdge = cur.sy2[5] && !cur.sy3[5];
	assign eblHigh = cur.sy2[1];
	assign eblFell = !cur.sy2[1] && cur.sy3[1];
	assign excRose = cur.sy2[2] && !cur.sy3[2];
	assign statRead = cur.stat | ({31'h0, busy} << ST_BUSY) | ({31'h0, cur.sy2[4]} << ST_ATTENTION_FLAG);
	assign newVaddr = cur.vaddr + VADDR_STEP;
	assign entry = cur.map[newVaddr[16:9]];

	always_comb
	begin
		prdata = 32'h00000000;
		if (rd && isMap)
		begin
			prdata = {cur.map[paddr[9:2]][MAP_VALID], 10'h000, cur.map[paddr[9:2]][20:0]};
		end
		else if (rd && paddr == CTRL_OFS)
		begin
			prdata = {28'h0000000, cur.maint, cur.ie, cur.abortBit, 1'b0};
		end
		else if (rd && paddr == STAT_OFS)
		begin
			prdata = statRead;
		end
		else if (rd && paddr == VADDR_OFS)
		begin
			prdata = cur.vaddr;
		end
	end

	always_comb
	begin
		next_cur = cur;
		setv = 32'h00000000;
		w1c = 32'h00000000;
		next_cur.sy1 = {syncClock, attention_line, occupied_line, drive_exception_line,
			end_of_block, transfer_acknowledge};
		next_cur.sy2 = cur.sy1;
		next_cur.sy3 = cur.sy2;
		next_cur.retry = 1'b0;
		next_cur.zeroData = 1'b0;
		next_cur.initPulse = 1'b0;
		if (cur.initCnt != 4'h0)
		begin
			next_cur.initCnt = cur.initCnt - 4'h1;
		end
		if (wr && paddr == STAT_OFS)
		begin
			w1c = pwdata & STAT_W1C;
		end
		if (noRespConf)
		begin
			setv[ST_NO_RESPONSE_FLAG] = 1'b1;
			next_cur.retry = 1'b1;
		end
		if (readCorrected)
		begin
			setv[ST_CRD] = 1'b1;
		end
		if (ctlParityErr)
		begin
			setv[ST_CONTROL_PARITY_FLAG] = 1'b1;
		end
		if (excRose)
		begin
			setv[ST_EXC] = 1'b1;
		end
		// Program errors: the offending load or start is dropped.
		if (busy && xferCmd)
		begin
			setv[ST_PGE] = 1'b1;
		end
		if (wr && busy && (isMap || paddr == VADDR_OFS || paddr == BCNT_OFS))
		begin
			setv[ST_PGE] = 1'b1;
		end
		if (wr && busy && paddr == CTRL_OFS && pwdata[CTRL_MAINT])
		begin
			setv[ST_PGE] = 1'b1;
		end
		if (wr && !busy && isMap)
		begin
			next_cur.map[paddr[9:2]] = {pwdata[31], ~^pwdata[20:0], pwdata[20:0]};
		end
		if (wr && !busy && paddr == VADDR_OFS)
		begin
			next_cur.vaddr = pwdata;
		end
		if (wr && paddr == CTRL_OFS)
		begin
			next_cur.abortBit = pwdata[CTRL_ABORT];
			next_cur.ie = pwdata[CTRL_IE];
			if (!busy)
			begin
				next_cur.maint = pwdata[CTRL_MAINT];
			end
		end
		// Drive presence watchdog, once per demand.
		if (demand_line && !cur.sy2[0] && !cur.nfdDone)
		begin
			next_cur.nfdCnt = cur.nfdCnt + 8'h01;
			if (cur.nfdCnt == NFD_CYC)
			begin
				setv[ST_NFD] = 1'b1;
				next_cur.zeroData = 1'b1;
				next_cur.nfdDone = 1'b1;
			end
		end
		if (!demand_line)
		begin
			next_cur.nfdCnt = 8'h00;
			next_cur.nfdDone = 1'b0;
		end
		// Backplane sequence and read data watchdogs.
		if (seqStart)
		begin
			next_cur.seqOn = 1'b1;
			next_cur.seqCnt = 15'h0000;
		end
		else if (seqEnd)
		begin
			next_cur.seqOn = 1'b0;
		end
		else if (cur.seqOn)
		begin
			next_cur.seqCnt = cur.seqCnt + 15'h0001;
			if (cur.seqCnt == 15'(SEQ_CYC))
			begin
				setv[ST_ISTO] = 1'b1;
				next_cur.seqOn = 1'b0;
			end
		end
		if (readSeqDone)
		begin
			next_cur.rdOn = 1'b1;
			next_cur.rdCnt = 15'h0000;
		end
		else if (readDataBack)
		begin
			next_cur.rdOn = 1'b0;
		end
		else if (cur.rdOn)
		begin
			next_cur.rdCnt = cur.rdCnt + 15'h0001;
			if (cur.rdCnt == 15'(SEQ_CYC))
			begin
				setv[ST_RDTO] = 1'b1;
				next_cur.rdOn = 1'b0;
			end
		end
		if (errConf)
		begin
			setv[ST_ERRCF] = 1'b1;
		end
		if (readSubstitute)
		begin
			setv[ST_RDS] = 1'b1;
		end
		if (cur.xs == X_RUN)
		begin
			if (cur.mxfOn)
			begin
				next_cur.mxfCnt = cur.mxfCnt + 17'h00001;
				if (sclkEdge || cur.sy2[3])
				begin
					next_cur.mxfOn = 1'b0;
				end
				else if (cur.mxfCnt == 17'(MXF_CYC))
				begin
					setv[ST_MXF] = 1'b1;
					next_cur.mxfOn = 1'b0;
				end
			end
			if (xferMode == MODE_READ && sclkEdge && bufFull)
			begin
				setv[ST_DLT] = 1'b1;
			end
			if (xferMode != MODE_READ && wclkSent && bufEmpty)
			begin
				setv[ST_DLT] = 1'b1;
			end
			if (xferMode == MODE_WCHECK && wcStrobe)
			begin
				setv[ST_WCKU] = wcMemWord[15:8] != wcDriveWord[15:8];
				setv[ST_WCKL] = wcMemWord[7:0] != wcDriveWord[7:0];
			end
			if (xferMode == MODE_READ && dataParityErr)
			begin
				setv[ST_DPE] = 1'b1;
			end
			if (memXfer)
			begin
				next_cur.vaddr = newVaddr;
				next_cur.physAddr = {entry[20:0], newVaddr[8:0]};
				if (^entry[21:0] != 1'b1)
				begin
					setv[ST_MAP_PARITY_FLAG] = 1'b1;
				end
				if (newVaddr[8:0] == 9'h000 && !entry[MAP_VALID] && byteCountNonzero)
				begin
					setv[ST_INVALID_MAP_FLAG] = 1'b1;
				end
			end
		end
		abortEv = (setv & ABORT_MASK) != 32'h00000000 || (wr && paddr == CTRL_OFS && pwdata[CTRL_ABORT]);
		unique case (cur.xs)
			X_IDLE:
			begin
				if (xferCmd)
				begin
					next_cur.xs = X_RUN;
					next_cur.mxfOn = 1'b1;
					next_cur.mxfCnt = 17'h00000;
					next_cur.physAddr = {cur.map[cur.vaddr[16:9]][20:0], cur.vaddr[8:0]};
				end
			end
			X_RUN:
			begin
				if (abortEv)
				begin
					next_cur.xs = X_ABWAIT;
					next_cur.mxfOn = 1'b0;
				end
				else if (xferDone)
				begin
					next_cur.xs = X_IDLE;
					setv[ST_CMP] = 1'b1;
				end
			end
			X_ABWAIT:
			begin
				if (eblHigh)
				begin
					next_cur.xs = X_ABEBL;
				end
			end
			X_ABEBL:
			begin
				if (eblFell)
				begin
					next_cur.xs = X_IDLE;
					setv[ST_ABT] = 1'b1;
					setv[ST_CMP] = 1'b1;
				end
			end
		endcase
		// A flag raised in the same cycle as its write-one clear stays set.
		next_cur.stat = ((cur.stat & ~w1c) | setv) & ~(32'h1 << ST_BUSY) & ~(32'h1 << ST_ATTENTION_FLAG);
		if (wr && paddr == CTRL_OFS && pwdata[CTRL_INIT])
		begin
			next_cur.stat = 32'h00000000;
			next_cur.abortBit = 1'b0;
			next_cur.ie = 1'b0;
			next_cur.xs = X_IDLE;
			next_cur.mxfOn = 1'b0;
			next_cur.seqOn = 1'b0;
			next_cur.retry = 1'b0;
			next_cur.initCnt = INIT_HOLD_CYC;
			next_cur.initPulse = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.ie <= IE_RESET;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign demand_line = demandReq && !cur.maint;
	assign runLine = cur.xs == X_RUN;
	assign execute_line = cur.xs == X_ABWAIT || cur.xs == X_ABEBL;
	assign driveInit = cur.initCnt != 4'h0;
	assign adapterInit = cur.initPulse;
	assign retryCmd = cur.retry;
	assign missingDriveZero = cur.zeroData;
	assign byteCountWrite = wr && !busy && paddr == BCNT_OFS;
	assign physAddr = cur.physAddr;
	assign irq = cur.ie && (statRead & IRQ_MASK) != 32'h00000000;

	a_init_reads_zero: assert property (@(posedge clk) disable iff (rst)
		(rd && paddr == CTRL_OFS) |-> !prdata[CTRL_INIT]) else $error("init bit read as one");
	a_init_clears: assert property (@(posedge clk) disable iff (rst)
		(wr && paddr == CTRL_OFS && pwdata[CTRL_INIT]) |=> (cur.stat == 32'h0 && !cur.ie && driveInit
		&& adapterInit && !busy)) else $error("initialize left state behind");
	a_busy_on_cmd: assert property (@(posedge clk) disable iff (rst)
		(!busy && xferCmd && !wr) |=> (statRead[ST_BUSY] && runLine)) else $error("busy not set");
	a_nfd_timeout: assert property (@(posedge clk) disable iff (rst)
		(demand_line && !cur.sy2[0] && !cur.nfdDone && cur.nfdCnt == NFD_CYC) |=>
		(cur.stat[ST_NFD] && missingDriveZero)) else $error("missing drive not flagged");
	a_abort_execute_line: assert property (@(posedge clk) disable iff (rst)
		(runLine && setv[ST_DLT] && !wr) |=> (execute_line && !runLine)) else $error("abort not started");
	a_abt_on_ebl: assert property (@(posedge clk) disable iff (rst)
		(cur.xs == X_ABEBL && eblFell && !wr) |=> (cur.stat[ST_ABT] && cur.stat[ST_CMP] && !busy))
		else $error("aborted flag missed end of block");
	a_vaddr_step: assert property (@(posedge clk) disable iff (rst)
		(runLine && memXfer && !wr) |=> (cur.vaddr == $past(cur.vaddr) + VADDR_STEP))
		else $error("address did not step by eight");
	a_pge_load: assert property (@(posedge clk) disable iff (rst)
		(busy && wr && paddr == VADDR_OFS && !memXfer) |=> (cur.stat[ST_PGE]
		&& cur.vaddr == $past(cur.vaddr))) else $error("load during transfer not flagged");
	a_irq_gate: assert property (@(posedge clk) disable iff (rst)
		(cur.ie && cur.stat[ST_CMP]) |-> irq) else $error("interrupt gating wrong");
	a_irq_masked: assert property (@(posedge clk) disable iff (rst)
		!cur.ie |-> !irq) else $error("interrupt raised while disabled");
	a_seq_timeout: assert property (@(posedge clk) disable iff (rst)
		(cur.seqOn && !seqStart && !seqEnd && cur.seqCnt == 15'(SEQ_CYC) && runLine && !wr) |=>
		(cur.stat[ST_ISTO] && execute_line)) else $error("sequence timeout missed");
endmodule : dbas_status
`default_nettype wire

// *** tb/dbas_drive_model.sv ***
// Drive-bus partner for the adapter status bench: acknowledges demand and
// closes an aborted block with an end-of-block pulse. Runs on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module dbas_drive_model (
	input wire logic clk, // backplane clock
	input wire logic rst, // async reset, active high
	input wire logic demand_line, // demand from adapter
	input wire logic execute_line, // execute from adapter
	input wire logic ackOn, // low models an absent drive
	output logic transfer_acknowledge, // acknowledge pin
	output logic end_of_block // end-of-block pin
);
	logic [3:0] ackCnt;
	logic [3:0] eblCnt;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ackCnt <= 4'h0;
			eblCnt <= 4'h0;
		end
		else
		begin
			if (!demand_line || !ackOn)
				ackCnt <= 4'h0;
			else if (ackCnt != 4'h8)
				ackCnt <= ackCnt + 4'h1;
			if (execute_line && eblCnt == 4'h0)
				eblCnt <= 4'h1;
			else if (eblCnt != 4'h0 && eblCnt != 4'hC)
				eblCnt <= eblCnt + 4'h1;
			else if (!execute_line)
				eblCnt <= 4'h0;
		end
	end
	// A present drive answers well inside the demand window.
	assign transfer_acknowledge = (ackCnt == 4'h8);
	// End-of-block rises, then falls while execute is still held.
	assign end_of_block = (eblCnt >= 4'h4) && (eblCnt < 4'hA);
endmodule : dbas_drive_model
`default_nettype wire

// *** tb/dbas_status_test.sv ***
// Self-checking bench for the adapter status block.
// Assumes zero-wait APB and the drive model on the drive-bus pins.
`timescale 1ns/1ps
`default_nettype none
module dbas_status_test;
	import dbas_pkg::*;
	localparam int MXF_SIM = 40;
	localparam int SEQ_SIM = 30;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic xferCmd, xferDone, byteCountNonzero, memXfer, noRespConf, errConf;
	logic readCorrected, readSubstitute, seqStart, seqEnd, readSeqDone, readDataBack;
	logic wclkSent, bufEmpty, bufFull, ctlParityErr, dataParityErr, wcStrobe, demandReq;
	logic [1:0] xferMode;
	logic [15:0] wcMemWord, wcDriveWord;
	logic transfer_acknowledge, end_of_block, drive_exception_line, occupied_line;
	logic attention_line, syncClock, demand_line, runLine, execute_line, driveInit;
	logic adapterInit, retryCmd, missingDriveZero, byteCountWrite, irq, rerr, linkOn, ackOn;
	logic [29:0] physAddr;
	int err_total, check_count, cycles;
	int causeBit [10] = '{ST_ERRCF, ST_RDS, ST_DPE, ST_DLT, ST_WCKU, ST_WCKL, ST_ISTO,
		ST_RDTO, ST_EXC, 0};
	dbas_status #(.MXF_CYC(MXF_SIM), .SEQ_CYC(SEQ_SIM)) dbas_status_i (.clk, .rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .xferCmd, .xferMode,
		.xferDone, .byteCountNonzero, .memXfer, .noRespConf, .errConf, .readCorrected,
		.readSubstitute, .seqStart, .seqEnd, .readSeqDone, .readDataBack, .wclkSent,
		.bufEmpty, .bufFull, .ctlParityErr, .dataParityErr, .wcStrobe, .wcMemWord,
		.wcDriveWord, .demandReq, .transfer_acknowledge, .end_of_block,
		.drive_exception_line, .occupied_line, .attention_line, .syncClock, .demand_line,
		.runLine, .execute_line, .driveInit, .adapterInit, .retryCmd, .missingDriveZero,
		.byteCountWrite, .physAddr, .irq);
	dbas_drive_model dbas_drive_model_i (.clk, .rst, .demand_line, .execute_line, .ackOn,
		.transfer_acknowledge, .end_of_block);
	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end
	// The link clock only runs inside a transfer, like a real drive's.
	initial
	begin
		syncClock = 1'b0;
		forever
		begin
			#32;
			syncClock = linkOn ? ~syncClock : 1'b0;
		end
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			wrap_up();
		end
	end
	function automatic logic [31:0] bitv(input int b);
		return 32'h00000001 << b;
	endfunction : bitv
	task wrap_up();
		$display("Checks %0d, errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n)
			@(posedge clk);
	endtask : tick
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps a following call from driving psel twice in a step.
		@(posedge clk);
	endtask : apb
	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask : rd
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task waitStat(input int b);
		int n;
		n = 0;
		rd(STAT_OFS);
		while (rdat[b] !== 1'b1 && n < 200)
		begin
			rd(STAT_OFS);
			n++;
		end
	endtask : waitStat
	task startXfer(input logic [1:0] m);
		xferMode <= m;
		xferCmd <= 1'b1;
		@(posedge clk);
		xferCmd <= 1'b0;
		tick(3);
	endtask : startXfer
	task waitExec();
		int n;
		n = 0;
		while (execute_line !== 1'b1 && n < 80)
		begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, execute_line}, 32'h00000001);
		chk({31'h0, runLine}, 32'h00000000);
	endtask : waitExec
	task t_reset();
		rd(STAT_OFS);
		chk(rdat, 32'h00000000);
		rd(CTRL_OFS);
		chk(rdat, 32'h00000004);
		rd(12'h3F0);
		chk({31'h0, rerr}, 32'h00000001);
		chk(rdat, 32'h00000000);
	endtask : t_reset
	task t_flags();
		int fb [3] = '{ST_NO_RESPONSE_FLAG, ST_CRD, ST_CONTROL_PARITY_FLAG};
		for (int i = 0; i < 3; i++)
		begin
			noRespConf <= (i == 0);
			readCorrected <= (i == 1);
			ctlParityErr <= (i == 2);
			@(posedge clk);
			noRespConf <= 1'b0;
			readCorrected <= 1'b0;
			ctlParityErr <= 1'b0;
			#1;
			chk({31'h0, retryCmd}, {31'h0, i == 0});
			@(posedge clk);
			rd(STAT_OFS);
			chk(rdat, bitv(fb[i]));
			chk({31'h0, irq}, {31'h0, i == 2});
			wr(STAT_OFS, bitv(fb[i]));
			rd(STAT_OFS);
			chk(rdat, 32'h00000000);
		end
	endtask : t_flags
	task t_abort();
		logic [31:0] exp;
		for (int i = 0; i < 10; i++)
		begin
			linkOn = 1'b1;
			wcMemWord <= (i == 4) ? 16'h35AB : 16'h34AC;
			startXfer((i == 3) ? MODE_WRITE : (i == 4 || i == 5) ? MODE_WCHECK : MODE_READ);
			chk({31'h0, runLine}, 32'h00000001);
			case (i)
				0: errConf <= 1'b1;
				1: readSubstitute <= 1'b1;
				2: dataParityErr <= 1'b1;
				3: {wclkSent, bufEmpty} <= 2'h3;
				4, 5: wcStrobe <= 1'b1;
				6: seqStart <= 1'b1;
				7: readSeqDone <= 1'b1;
				8: drive_exception_line <= 1'b1;
				default: wr(CTRL_OFS, 32'h00000006);
			endcase
			@(posedge clk);
			{errConf, readSubstitute, dataParityErr, wclkSent, bufEmpty} <= 5'h00;
			{wcStrobe, seqStart, readSeqDone} <= 3'h0;
			if (i == 8)
				tick(3);
			drive_exception_line <= 1'b0;
			waitExec();
			rd(STAT_OFS);
			chk({31'h0, rdat[ST_ABT]}, 32'h00000000);
			waitStat(ST_ABT);
			exp = bitv(ST_ABT) | bitv(ST_CMP) | ((i < 9) ? bitv(causeBit[i]) : 32'h00000000);
			chk(rdat, exp);
			chk({31'h0, irq}, 32'h00000001);
			wr(STAT_OFS, 32'hFFFFFFFF);
			linkOn = 1'b0;
			tick(4);
		end
	endtask : t_abort
	task t_var();
		wr(12'h80C, 32'h8010ABCD);
		rd(12'h80C);
		chk(rdat, 32'h8010ABCD);
		wr(12'h810, 32'h00000000);
		wr(VADDR_OFS, 32'h000007F0);
		linkOn = 1'b1;
		startXfer(MODE_READ);
		memXfer <= 1'b1;
		@(posedge clk);
		memXfer <= 1'b0;
		tick(2);
		rd(VADDR_OFS);
		chk(rdat, 32'h000007F8);
		chk({2'h0, physAddr}, {2'h0, 21'h10ABCD, 9'h1F8});
		wr(VADDR_OFS, 32'h00000000);
		rd(VADDR_OFS);
		chk(rdat, 32'h000007F8);
		// Stepping onto page 4 with bytes left finds its entry invalid.
		byteCountNonzero <= 1'b1;
		memXfer <= 1'b1;
		@(posedge clk);
		memXfer <= 1'b0;
		waitExec();
		waitStat(ST_ABT);
		chk(rdat, bitv(ST_PGE) | bitv(ST_INVALID_MAP_FLAG) | bitv(ST_ABT) | bitv(ST_CMP));
		rd(VADDR_OFS);
		chk(rdat, 32'h00000800);
		byteCountNonzero <= 1'b0;
		wr(STAT_OFS, 32'hFFFFFFFF);
		linkOn = 1'b0;
	endtask : t_var
	task t_timers();
		startXfer(MODE_READ);
		tick(MXF_SIM - 15);
		rd(STAT_OFS);
		chk(rdat, bitv(ST_BUSY));
		tick(20);
		rd(STAT_OFS);
		chk(rdat, bitv(ST_BUSY) | bitv(ST_MXF));
		chk({31'h0, irq}, 32'h00000001);
		xferDone <= 1'b1;
		@(posedge clk);
		xferDone <= 1'b0;
		tick(2);
		rd(STAT_OFS);
		chk(rdat, bitv(ST_MXF) | bitv(ST_CMP));
		wr(STAT_OFS, 32'hFFFFFFFF);
		ackOn = 1'b0;
		demandReq <= 1'b1;
		tick(150);
		rd(STAT_OFS);
		chk(rdat, 32'h00000000);
		waitStat(ST_NFD);
		chk(rdat, bitv(ST_NFD));
		demandReq <= 1'b0;
		wr(STAT_OFS, 32'hFFFFFFFF);
		ackOn = 1'b1;
		demandReq <= 1'b1;
		tick(220);
		rd(STAT_OFS);
		chk(rdat, 32'h00000000);
		demandReq <= 1'b0;
	endtask : t_timers
	task t_init();
		attention_line <= 1'b1;
		readCorrected <= 1'b1;
		@(posedge clk);
		readCorrected <= 1'b0;
		tick(5);
		rd(STAT_OFS);
		chk(rdat, bitv(ST_ATTENTION_FLAG) | bitv(ST_CRD));
		chk({31'h0, irq}, 32'h00000001);
		wr(CTRL_OFS, 32'h00000001);
		tick(1);
		chk({31'h0, driveInit}, 32'h00000001);
		rd(CTRL_OFS);
		chk(rdat, 32'h00000000);
		rd(STAT_OFS);
		chk(rdat, bitv(ST_ATTENTION_FLAG));
		chk({31'h0, irq}, 32'h00000000);
		wr(CTRL_OFS, 32'h00000004);
		tick(1);
		chk({31'h0, irq}, 32'h00000001);
		attention_line <= 1'b0;
		tick(20);
		chk({31'h0, irq}, 32'h00000000);
		chk({31'h0, driveInit}, 32'h00000000);
	endtask : t_init
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, xferCmd, xferDone, byteCountNonzero} = '0;
		{memXfer, noRespConf, errConf, readCorrected, readSubstitute, seqStart, seqEnd} = '0;
		{readSeqDone, readDataBack, wclkSent, bufEmpty, bufFull, ctlParityErr} = '0;
		{dataParityErr, wcStrobe, demandReq, xferMode, drive_exception_line} = '0;
		{occupied_line, attention_line, linkOn, err_total, check_count, cycles} = '0;
		wcMemWord = 16'h0000;
		wcDriveWord = 16'h34AB;
		ackOn = 1'b1;
		rst = 1'b1;
		tick(6);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_flags();
		t_abort();
		t_var();
		t_timers();
		t_init();
		wrap_up();
	end
endmodule : dbas_status_test
`default_nettype wire
